// [pkg/mipc_pkg.sv]
// constants for the input path control registers
// assumes a 7-bit address, 9-bit data register write port
package mipc_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int REG_W = 9;
    localparam int CODE_W = 6;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_PWR_ONE = 7'h01;
    localparam logic [6:0] ADDR_PWR_TWO = 7'h02;
    localparam logic [6:0] ADDR_LVL_ONE = 7'h20;
    localparam logic [6:0] ADDR_ROUTE = 7'h2c;
    localparam logic [6:0] ADDR_GAIN = 7'h2d;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [8:0] RST_PWR_ONE = 9'h000;
    localparam logic [8:0] RST_PWR_TWO = 9'h000;
    localparam logic [8:0] RST_LVL_ONE = 9'h000;
    localparam logic [8:0] RST_ROUTE = 9'h002;
    localparam logic [8:0] RST_GAIN = 9'h050;
    localparam logic [5:0] RST_CODE = 6'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int AUX_EN_BIT = 6;
    localparam int AMP_EN_BIT = 2;
    localparam int ALC_SEL_BIT = 8;
    localparam int AUX_MODE_BIT = 3;
    localparam int AUX_SEL_BIT = 2;
    localparam int NEG_SEL_BIT = 1;
    localparam int POS_SEL_BIT = 0;
    localparam int ZC_BIT = 7;
    localparam int MUTE_BIT = 6;
    localparam int CODE_MSB = 5;
    localparam int CODE_LSB = 0;
endpackage

// [src/mipc_path_ctrl.sv]
// input path control registers: routing, gain amp, aux amp
// assumes a serial port decoder on mclk_in driving the write port,
// an asynchronous zero-cross comparator and an alc loop on mclk_in
//
// Behaviour
// [R1] routing bit 2 connects aux amp to negative terminal; reset 0
// [R2] routing bit 1 connects negative mic pin; reset 1
// [R3] routing bit 0 picks positive terminal: mid rail or mic pin
// [R4] power two bit 2 enables the gain amplifier; reset off
// [R5] 6-bit code, -12dB to 35.25dB in 0.75dB steps; reset 0dB
// [R6] one gain code shared by all negative and positive paths
// [R7] zero-cross bit set delays new gain to next zero crossing
// [R8] gain bit 6 mutes and isolates the amplifier; reset muted
// [R9] level control bit 8 hands gain to the alc loop
// [R10] software should not write gain code while alc owns it
// [R11] power one bit 6 powers the aux amplifier; reset off
// [R12] routing bit 3 picks aux buffer or mixer bypass mode
// [R13] reset loads defaults; a write updates all fields at once
`timescale 1ns/10ps

module mipc_path_ctrl (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic reg_wr_in,
    input wire logic [6:0] reg_addr_in,
    input wire logic [8:0] reg_wdata_in,
    input wire logic zero_cross_in,
    input wire logic [5:0] alc_gain_code_in,
    output logic [8:0] reg_rdata_out,
    output logic aux_to_amp_select_out,
    output logic neg_mic_to_amp_select_out,
    output logic pos_terminal_source_select_out,
    output logic gain_amp_power_enable_out,
    output logic [5:0] gain_amp_code_out,
    output logic gain_amp_mute_out,
    output logic auto_level_select_out,
    output logic aux_amp_power_enable_out,
    output logic aux_amp_mode_select_out,
    output logic aux_resistor_bypass_switch_out,
    output logic gain_update_pending_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [8:0] pwr_one;
    logic [8:0] pwr_two;
    logic [8:0] lvl_one;
    logic [8:0] route;
    logic [8:0] gain;
    logic [5:0] applied_code;
    logic pending;
    logic [5:0] gain_out;
    logic [8:0] rdata;
    logic zc_meta;
    logic zc_s2;
    logic zc_s3;
    logic zc_lvl;
    logic [8:0] next_pwr_one;
    logic [8:0] next_pwr_two;
    logic [8:0] next_lvl_one;
    logic [8:0] next_route;
    logic [8:0] next_gain;
    logic [5:0] next_applied_code;
    logic next_pending;
    logic [5:0] next_gain_out;
    logic [8:0] next_rdata;
    logic next_zc_lvl;
    logic zc_event;
    logic wr_gain;

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    always_comb begin
        next_pwr_one = pwr_one;
        next_pwr_two = pwr_two;
        next_lvl_one = lvl_one;
        next_route = route;
        next_gain = gain;
        next_applied_code = applied_code;
        next_pending = pending;
        next_zc_lvl = zc_lvl;
        zc_event = 1'b0;
        wr_gain = reg_wr_in && (reg_addr_in == mipc_pkg::ADDR_GAIN);
        // whole-word writes
        if (reg_wr_in) begin // R13
            case (reg_addr_in)
                mipc_pkg::ADDR_PWR_ONE: next_pwr_one = reg_wdata_in; // R11
                mipc_pkg::ADDR_PWR_TWO: next_pwr_two = reg_wdata_in; // R4
                mipc_pkg::ADDR_LVL_ONE: next_lvl_one = reg_wdata_in; // R9
                mipc_pkg::ADDR_ROUTE: next_route = reg_wdata_in; // R1 R2 R3 R12
                mipc_pkg::ADDR_GAIN: next_gain = reg_wdata_in; // R8
                default: next_route = route;
            endcase
        end
        // zero crossing once two synced samples agree
        if ((zc_s2 == zc_s3) && (zc_s3 != zc_lvl)) begin
            next_zc_lvl = zc_s3;
            zc_event = 1'b1;
        end
        if (zc_event && pending) begin // R7
            next_applied_code = gain[mipc_pkg::CODE_MSB:mipc_pkg::CODE_LSB];
            next_pending = 1'b0;
        end
        // a new write wins over a crossing in the same cycle
        if (wr_gain) begin // R7
            if (reg_wdata_in[mipc_pkg::ZC_BIT]) begin
                next_pending = 1'b1;
                next_applied_code = applied_code;
            end else begin
                next_pending = 1'b0;
                next_applied_code =
                    reg_wdata_in[mipc_pkg::CODE_MSB:mipc_pkg::CODE_LSB];
            end
        end
        // shared gain, from alc loop or software
        if (next_lvl_one[mipc_pkg::ALC_SEL_BIT]) begin // R9 R10
            next_gain_out = alc_gain_code_in;
        end else begin
            next_gain_out = next_applied_code; // R5 R6
        end
        case (reg_addr_in)
            mipc_pkg::ADDR_PWR_ONE: next_rdata = pwr_one;
            mipc_pkg::ADDR_PWR_TWO: next_rdata = pwr_two;
            mipc_pkg::ADDR_LVL_ONE: next_rdata = lvl_one;
            mipc_pkg::ADDR_ROUTE: next_rdata = route;
            mipc_pkg::ADDR_GAIN: next_rdata = gain;
            default: next_rdata = 9'h000;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin // R13
            pwr_one <= mipc_pkg::RST_PWR_ONE; // R11
            pwr_two <= mipc_pkg::RST_PWR_TWO; // R4
            lvl_one <= mipc_pkg::RST_LVL_ONE; // R9
            route <= mipc_pkg::RST_ROUTE; // R1 R2 R3
            gain <= mipc_pkg::RST_GAIN; // R8
            applied_code <= mipc_pkg::RST_CODE; // R5
            pending <= 1'b0;
            gain_out <= mipc_pkg::RST_CODE;
            rdata <= 9'h000;
            zc_meta <= 1'b0;
            zc_s2 <= 1'b0;
            zc_s3 <= 1'b0;
            zc_lvl <= 1'b0;
        end else if (ce_in) begin
            pwr_one <= next_pwr_one;
            pwr_two <= next_pwr_two;
            lvl_one <= next_lvl_one;
            route <= next_route;
            gain <= next_gain;
            applied_code <= next_applied_code;
            pending <= next_pending;
            gain_out <= next_gain_out;
            rdata <= next_rdata;
            zc_meta <= zero_cross_in;
            zc_s2 <= zc_meta;
            zc_s3 <= zc_s2;
            zc_lvl <= next_zc_lvl;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_out = rdata;
    assign aux_to_amp_select_out = route[mipc_pkg::AUX_SEL_BIT]; // R1
    assign neg_mic_to_amp_select_out = route[mipc_pkg::NEG_SEL_BIT]; // R2
    assign pos_terminal_source_select_out =
        route[mipc_pkg::POS_SEL_BIT]; // R3
    assign gain_amp_power_enable_out = pwr_two[mipc_pkg::AMP_EN_BIT]; // R4
    assign gain_amp_code_out = gain_out; // R6
    assign gain_amp_mute_out = gain[mipc_pkg::MUTE_BIT]; // R8
    assign auto_level_select_out = lvl_one[mipc_pkg::ALC_SEL_BIT]; // R9
    assign aux_amp_power_enable_out = pwr_one[mipc_pkg::AUX_EN_BIT]; // R11
    assign aux_amp_mode_select_out = route[mipc_pkg::AUX_MODE_BIT]; // R12
    assign aux_resistor_bypass_switch_out =
        route[mipc_pkg::AUX_MODE_BIT]; // R12
    assign gain_update_pending_out = pending;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_route_aux_sel: assert property ( // R1
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && reg_wr_in && reg_addr_in == mipc_pkg::ADDR_ROUTE)
        |=> aux_to_amp_select_out
            == $past(reg_wdata_in[mipc_pkg::AUX_SEL_BIT]))
        else $error("aux select not taken from routing write");

    a_route_neg_sel: assert property ( // R2
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && reg_wr_in && reg_addr_in == mipc_pkg::ADDR_ROUTE)
        |=> neg_mic_to_amp_select_out
            == $past(reg_wdata_in[mipc_pkg::NEG_SEL_BIT]))
        else $error("negative mic select not taken from write");

    a_route_pos_sel: assert property ( // R3
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && reg_wr_in && reg_addr_in == mipc_pkg::ADDR_ROUTE)
        |=> pos_terminal_source_select_out
            == $past(reg_wdata_in[mipc_pkg::POS_SEL_BIT]))
        else $error("positive source select not taken from write");

    a_amp_power_on: assert property ( // R4
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && reg_wr_in && reg_addr_in == mipc_pkg::ADDR_PWR_TWO)
        |=> gain_amp_power_enable_out
            == $past(reg_wdata_in[mipc_pkg::AMP_EN_BIT]))
        else $error("gain amp enable not taken from write");

    a_gain_direct_apply: assert property ( // R7
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && reg_wr_in && reg_addr_in == mipc_pkg::ADDR_GAIN
            && !reg_wdata_in[mipc_pkg::ZC_BIT]
            && !next_lvl_one[mipc_pkg::ALC_SEL_BIT])
        |=> gain_amp_code_out
            == $past(reg_wdata_in[mipc_pkg::CODE_MSB:mipc_pkg::CODE_LSB]))
        else $error("gain code not applied at once");

    a_gain_zc_hold: assert property ( // R7
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && pending && !zc_event && !wr_gain)
        |=> applied_code == $past(applied_code) && pending)
        else $error("gain changed before zero crossing");

    a_mute_follows: assert property ( // R8
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && wr_gain)
        |=> gain_amp_mute_out == $past(reg_wdata_in[mipc_pkg::MUTE_BIT]))
        else $error("mute not taken from gain write");

    a_alc_owns_gain: assert property ( // R9
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && next_lvl_one[mipc_pkg::ALC_SEL_BIT])
        |=> gain_amp_code_out == $past(alc_gain_code_in))
        else $error("alc gain not passed while alc selected");

    a_aux_power_on: assert property ( // R11
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && reg_wr_in && reg_addr_in == mipc_pkg::ADDR_PWR_ONE)
        |=> aux_amp_power_enable_out
            == $past(reg_wdata_in[mipc_pkg::AUX_EN_BIT]))
        else $error("aux enable not taken from write");

    a_aux_mode_sw: assert property ( // R12
        @(posedge mclk_in) disable iff (sys_rst_in)
        aux_resistor_bypass_switch_out == aux_amp_mode_select_out)
        else $error("aux bypass switch disagrees with mode");

    a_aux_mode_taken: assert property ( // R12
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && reg_wr_in && reg_addr_in == mipc_pkg::ADDR_ROUTE)
        |=> aux_amp_mode_select_out
            == $past(reg_wdata_in[mipc_pkg::AUX_MODE_BIT]))
        else $error("aux mode not taken from routing write");

    a_aux_bypass_taken: assert property ( // R12
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && reg_wr_in && reg_addr_in == mipc_pkg::ADDR_ROUTE)
        |=> aux_resistor_bypass_switch_out
            == $past(reg_wdata_in[mipc_pkg::AUX_MODE_BIT]))
        else $error("aux bypass switch not taken from write");

    a_freeze_hold: assert property ( // R13
        @(posedge mclk_in) disable iff (sys_rst_in)
        !ce_in |=> $stable(route) && $stable(gain) && $stable(pending)
            && $stable(gain_amp_code_out))
        else $error("state moved while clock enable low");

    a_write_whole_word: assert property ( // R13
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && wr_gain) |=> gain == $past(reg_wdata_in))
        else $error("gain register not written as a whole");

    a_reset_defaults: assert property ( // R2 R8 R13
        @(posedge mclk_in)
        (sys_rst_in && $past(sys_rst_in))
        |-> neg_mic_to_amp_select_out && gain_amp_mute_out
            && !aux_to_amp_select_out && !pos_terminal_source_select_out
            && !gain_amp_power_enable_out && !aux_amp_power_enable_out
            && gain_amp_code_out == mipc_pkg::RST_CODE
            && !gain_update_pending_out)
        else $error("outputs not at defaults during reset");

    a_gain_zc_apply: assert property ( // R7
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && pending && zc_event && !wr_gain)
        |=> !pending && applied_code
            == $past(gain[mipc_pkg::CODE_MSB:mipc_pkg::CODE_LSB]))
        else $error("pending gain not applied at zero crossing");

    a_gain_zc_arm: assert property ( // R7
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && wr_gain && reg_wdata_in[mipc_pkg::ZC_BIT])
        |=> pending && applied_code == $past(applied_code))
        else $error("zero-cross write applied gain early");

    a_sw_gain_source: assert property ( // R6
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && !next_lvl_one[mipc_pkg::ALC_SEL_BIT])
        |=> gain_amp_code_out == applied_code)
        else $error("software gain not on the shared output");

    a_alc_sel_taken: assert property ( // R9
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && reg_wr_in && reg_addr_in == mipc_pkg::ADDR_LVL_ONE)
        |=> auto_level_select_out
            == $past(reg_wdata_in[mipc_pkg::ALC_SEL_BIT]))
        else $error("alc select not taken from write");

    a_readback_gain: assert property ( // R13
        @(posedge mclk_in) disable iff (sys_rst_in)
        (ce_in && reg_addr_in == mipc_pkg::ADDR_GAIN)
        |=> reg_rdata_out == $past(gain))
        else $error("gain register readback wrong");
endmodule

// [testbench/mipc_host_model.sv]
// host model: writes and reads the path control registers
// assumes the bench calls its tasks, one request at a time
`timescale 1ns/10ps

module mipc_host_model (
    input wire logic mclk_in,
    input wire logic [8:0] reg_rdata_in,
    output logic reg_wr_out,
    output logic [6:0] reg_addr_out,
    output logic [8:0] reg_wdata_out
);
    logic alc_on = 1'b0;
    initial begin
        reg_wr_out = 1'b0;
        reg_addr_out = 7'h00;
        reg_wdata_out = 9'h000;
    end
    // one-cycle strobe with address and data held across it
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        if (alc_on && a == mipc_pkg::ADDR_GAIN) return;
        @(posedge mclk_in);
        #1;
        reg_wr_out = 1'b1;
        reg_addr_out = a;
        reg_wdata_out = d;
        @(posedge mclk_in);
        #1;
        reg_wr_out = 1'b0;
        reg_wdata_out = ~d;
        if (a == mipc_pkg::ADDR_LVL_ONE) alc_on = d[8];
    endtask
    // readback answers one cycle after the address is taken
    task automatic rd(input logic [6:0] a, output logic [8:0] d);
        @(posedge mclk_in);
        #1;
        reg_addr_out = a;
        @(posedge mclk_in);
        #1;
        d = reg_rdata_in;
    endtask
endmodule

// [testbench/mipc_path_ctrl_tb.sv]
// bench for the input path control registers
// assumes the host model drives the write port
`timescale 1ns/10ps

module mipc_path_ctrl_tb;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic zero_cross_in = 1'b0;
    logic [5:0] alc_gain_code_in = 6'h00;
    logic wr, aux_sel, neg_sel, pos_sel, amp_en, mute, alc_sel, aux_en;
    logic aux_mode, bypass, pend;
    logic [6:0] addr;
    logic [8:0] wdata, rdata, rte, pw1, pw2, lvl, gn, v;
    logic [5:0] code, sw_code;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    always #50 mclk_in = ~mclk_in;

    mipc_host_model host (.mclk_in, .reg_rdata_in(rdata),
        .reg_wr_out(wr), .reg_addr_out(addr), .reg_wdata_out(wdata));
    mipc_path_ctrl uut (.mclk_in, .sys_rst_in, .ce_in,
        .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .zero_cross_in, .alc_gain_code_in, .reg_rdata_out(rdata),
        .aux_to_amp_select_out(aux_sel),
        .neg_mic_to_amp_select_out(neg_sel),
        .pos_terminal_source_select_out(pos_sel),
        .gain_amp_power_enable_out(amp_en), .gain_amp_code_out(code),
        .gain_amp_mute_out(mute), .auto_level_select_out(alc_sel),
        .aux_amp_power_enable_out(aux_en),
        .aux_amp_mode_select_out(aux_mode),
        .aux_resistor_bypass_switch_out(bypass),
        .gain_update_pending_out(pend));

    task automatic final_report();
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles > 5000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    function automatic logic [8:0] rb_exp(input logic [6:0] a);
        case (a)
            7'h01: rb_exp = pw1;
            7'h02: rb_exp = pw2;
            7'h20: rb_exp = lvl;
            7'h2c: rb_exp = rte;
            7'h2d: rb_exp = gn;
            default: rb_exp = 9'h000;
        endcase
    endfunction
    task automatic check_outs();
        chk(9'(aux_sel), 9'(rte[2]));
        chk(9'(neg_sel), 9'(rte[1]));
        chk(9'(pos_sel), 9'(rte[0]));
        chk(9'(amp_en), 9'(pw2[2]));
        chk(9'(mute), 9'(gn[6]));
        chk(9'(alc_sel), 9'(lvl[8]));
        chk(9'(aux_en), 9'(pw1[6]));
        chk(9'(aux_mode), 9'(rte[3]));
        chk(9'(bypass), 9'(rte[3]));
        chk(9'(code), 9'(lvl[8] ? alc_gain_code_in : sw_code));
    endtask
    task automatic read_all();
        logic [6:0] al [6] = '{7'h01, 7'h02, 7'h20, 7'h2c, 7'h2d, 7'h2e};
        foreach (al[i]) begin
            host.rd(al[i], v);
            chk(v, rb_exp(al[i]));
        end
    endtask
    task automatic wrs(input logic [6:0] a, input logic [8:0] d);
        host.wr(a, d);
        case (a)
            7'h01: pw1 = d;
            7'h02: pw2 = d;
            7'h20: lvl = d;
            7'h2c: rte = d;
            7'h2d: gn = d;
            default: ;
        endcase
        if (a == 7'h2d && !d[7]) sw_code = d[5:0];
        @(posedge mclk_in);
        #1;
        check_outs();
    endtask

    initial begin
        logic [6:0] ra [4] = '{7'h01, 7'h02, 7'h2c, 7'h2d};
        logic [6:0] a;
        logic [8:0] d;
        void'($urandom(32'h7280711f));
        {pw1, pw2, lvl, rte, gn, sw_code} = {9'h0, 9'h0, 9'h0, 9'h002,
            9'h050, 6'h10};
        repeat (3) @(posedge mclk_in);
        #1;
        sys_rst_in = 1'b0;
        check_outs();
        read_all();
        for (int i = 0; i < 24; i++) begin
            a = ra[$urandom_range(0, 3)];
            d = 9'($urandom);
            if (a == 7'h2d) d[7] = 1'b0;
            alc_gain_code_in = 6'($urandom);
            wrs(a, d);
        end
        wrs(7'h2d, 9'h000);
        wrs(7'h2d, 9'h03f);
        wrs(7'h2e, 9'h1ff);
        read_all();
        ce_in = 1'b0;
        host.wr(7'h2c, ~rte);
        ce_in = 1'b1;
        check_outs();
        wrs(7'h2d, 9'h0a0);
        chk(9'(pend), 9'h001);
        zero_cross_in = ~zero_cross_in;
        for (int i = 0; i < 10 && pend !== 1'b0; i++) begin
            @(posedge mclk_in);
            #1;
        end
        sw_code = 6'h20;
        chk(9'(pend), 9'h000);
        check_outs();
        zero_cross_in = ~zero_cross_in;
        repeat (8) @(posedge mclk_in);
        #1;
        check_outs();
        wrs(7'h20, 9'h100);
        alc_gain_code_in = 6'($urandom);
        @(posedge mclk_in);
        #1;
        check_outs();
        wrs(7'h20, 9'h000);
        read_all();
        final_report();
    end
endmodule
